// file: include/serial_port_pkg.sv
package serial_port_pkg;

    // Printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] idx_data = 8'h31;
    localparam logic [7:0] idx_control = 8'h32;
    localparam logic [7:0] idx_status = 8'h33;
    localparam logic [9:0] addr_data = {idx_data, 2'b00};
    localparam logic [9:0] addr_control = {idx_control, 2'b00};
    localparam logic [9:0] addr_status = {idx_status, 2'b00};
    localparam logic [9:0] addr_irq_status = 10'h0e0;
    localparam logic [9:0] addr_irq_mask = 10'h0e4;

    // Status bit positions
    localparam int bit_done = 7;
    localparam int bit_write_collision_flag = 6;
    localparam int bit_ovr = 5;
    localparam int bit_mode_fault_flag = 4;
    localparam int bit_sod = 2;
    localparam int bit_ssm = 1;
    localparam int bit_ssi = 0;

    // Control bit positions
    localparam int bit_irq_en = 7;
    localparam int bit_port_en = 6;
    localparam int bit_master = 4;

    // Interrupt status bit positions
    localparam int ev_done = 0;
    localparam int ev_ovr = 1;
    localparam int ev_mode_fault_flag = 2;
    localparam int ev_write_collision_flag = 3;

    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [3:0] irq_reset = 4'h0;

    // Serial clock in master mode: one half period of the link clock
    localparam int clk_period_ns = 10;
    localparam int sck_half_ns = 40;
    localparam int sck_half_cycles = (sck_half_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic [3:0] sck_half_load = 4'(sck_half_cycles - 1);
    localparam logic [3:0] bits_per_byte = 4'h8;

    typedef enum logic [1:0] {st_idle, st_low, st_high} shift_state_type;

    typedef struct packed {
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic sck_o;
        logic sck_oe;
    } pins_out_type;

    typedef struct packed {
        logic [2:0] sck;
        logic [1:0] ss_n;
        logic [1:0] mosi;
        logic [1:0] miso;
    } sync_type;

endpackage

// file: hw/serial_port.sv
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps

// Function
// - Set done bit 7, interrupt when enabled
// - Done cleared by status access then data access
// - Data writes ignored while done until status access
// - Write during transfer sets collision bit 6
// - New byte while done sets overrun bit 5
// - Overrun interrupts; status read clears it
// - Select low in master sets fault bit 4
// - Fault cleared by status access then control write
// - Output disable releases data output
// - Software select management ignores select pin
// - Internal select bit: 0 selects, 1 deselects
// - Master starts byte on data write
// - Received byte copied to buffer; reads return it
// - Data write loads shift register directly
// - Status resets to zero, bit 3 zero
// - Interrupt on done, fault or overrun when enabled
// - Fault clears port enable and master select
module serial_port
    import serial_port_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Serial pins
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    output pins_out_type pins_o,
    // Interrupt
    output logic irq
);

    typedef struct packed {
        logic a_valid;
        logic a_write;
        logic [9:0] a_addr;
        logic [31:0] rdata;
        logic [7:0] control;
        logic done;
        logic write_collision_flag;
        logic overrun_flag;
        logic mode_fault_flag;
        logic [2:0] csr_low;
        logic done_armed;
        logic write_collision_flag_armed;
        logic mode_fault_flag_armed;
        logic [7:0] shifter;
        logic [7:0] rx_buf;
        logic [3:0] bit_cnt;
        logic [3:0] div_cnt;
        shift_state_type state;
        logic busy;
        logic out_bit;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        pins_out_type pins;
        logic irq;
        sync_type sync;
    } state_type;

    state_type state_reg, state_next;

    function automatic logic [31:0] read_mux(input state_type s, input logic [9:0] a);
        read_mux = 32'h0000_0000;
        unique case (a)
            addr_data: read_mux = {24'h00_0000, s.rx_buf};
            addr_control: read_mux = {24'h00_0000, s.control};
            addr_status: read_mux = {24'h00_0000, s.done, s.write_collision_flag, s.overrun_flag, s.mode_fault_flag, 1'b0,
                s.csr_low};
            addr_irq_status: read_mux = {28'h000_0000, s.irq_status};
            addr_irq_mask: read_mux = {28'h000_0000, s.irq_mask};
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction

    logic take, sck_rise, sck_fall, ss_level, is_master, enabled, sel_fault;
    logic ev_done_p, ev_ovr_p, ev_mode_fault_flag_p, ev_write_collision_flag_p;
    logic wr_data, rd_data, wr_ctrl, rd_stat, wr_stat, rd_irq, wr_mask;
    logic last_edge;

    assign take = hsel && hready && htrans[1];
    assign hrdata = state_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign pins_o = state_reg.pins;
    assign irq = state_reg.irq;

    always_comb begin
        state_next = state_reg;
        // Address phase capture, data phase in the following cycle
        state_next.a_valid = take;
        state_next.a_write = hwrite;
        state_next.a_addr = haddr[9:0];
        wr_data = state_reg.a_valid && state_reg.a_write && state_reg.a_addr == addr_data;
        rd_data = state_reg.a_valid && !state_reg.a_write && state_reg.a_addr == addr_data;
        wr_ctrl = state_reg.a_valid && state_reg.a_write && state_reg.a_addr == addr_control;
        wr_stat = state_reg.a_valid && state_reg.a_write && state_reg.a_addr == addr_status;
        rd_stat = state_reg.a_valid && !state_reg.a_write && state_reg.a_addr == addr_status;
        rd_irq = state_reg.a_valid && !state_reg.a_write && state_reg.a_addr == addr_irq_status;
        wr_mask = state_reg.a_valid && state_reg.a_write && state_reg.a_addr == addr_irq_mask;

        // Pin synchronisers; second stages are read, and sck also its third stage for edge detection
        state_next.sync.sck = {state_reg.sync.sck[1:0], sck_i};
        state_next.sync.ss_n = {state_reg.sync.ss_n[0], ss_n_i};
        state_next.sync.mosi = {state_reg.sync.mosi[0], mosi_i};
        state_next.sync.miso = {state_reg.sync.miso[0], miso_i};
        sck_rise = state_reg.sync.sck[1] && !state_reg.sync.sck[2];
        sck_fall = !state_reg.sync.sck[1] && state_reg.sync.sck[2];

        is_master = state_reg.control[bit_master];
        enabled = state_reg.control[bit_port_en];
        ss_level = state_reg.csr_low[bit_ssm] ? state_reg.csr_low[bit_ssi]
            : state_reg.sync.ss_n[1];
        sel_fault = enabled && is_master && !ss_level;
        ev_done_p = 1'b0;
        ev_ovr_p = 1'b0;
        ev_write_collision_flag_p = 1'b0;
        ev_mode_fault_flag_p = 1'b0;
        last_edge = 1'b0;

        // Status access arms the done and fault clears; only a status read arms the collision clear
        if (rd_stat || wr_stat) begin
            state_next.done_armed = state_reg.done;
            state_next.mode_fault_flag_armed = state_reg.mode_fault_flag;
        end
        if (rd_stat) begin
            state_next.write_collision_flag_armed = state_reg.write_collision_flag;
            state_next.overrun_flag = 1'b0;
        end
        if (wr_stat) begin
            state_next.csr_low = hwdata[2:0];
        end
        if ((rd_data || wr_data) && state_reg.done_armed) begin
            state_next.done = 1'b0;
            state_next.done_armed = 1'b0;
        end
        if (rd_data && state_reg.write_collision_flag_armed) begin
            state_next.write_collision_flag = 1'b0;
            state_next.write_collision_flag_armed = 1'b0;
        end
        if (wr_ctrl) begin
            state_next.control = hwdata[7:0];
            if (state_reg.mode_fault_flag_armed) begin
                state_next.mode_fault_flag = 1'b0;
                state_next.mode_fault_flag_armed = 1'b0;
            end
        end

        // Data write: collision, inhibit, or load shifter
        if (wr_data) begin
            if (state_reg.busy) begin
                state_next.write_collision_flag = 1'b1;
                ev_write_collision_flag_p = 1'b1;
            end else if (state_reg.done && !state_reg.done_armed) begin
                state_next.done = state_reg.done;
            end else begin
                state_next.shifter = hwdata[7:0];
                state_next.bit_cnt = 4'h0;
                state_next.out_bit = hwdata[7];
                if (is_master && enabled) begin
                    state_next.busy = 1'b1;
                    state_next.state = st_low;
                    state_next.div_cnt = sck_half_load;
                end
            end
        end

        // Master clock generator and shifter
        unique case (state_reg.state)
            st_idle: begin
                state_next.pins.sck_o = 1'b0;
            end
            st_low: begin
                if (state_reg.div_cnt != 4'h0) begin
                    state_next.div_cnt = state_reg.div_cnt - 4'h1;
                end else begin
                    state_next.div_cnt = sck_half_load;
                    state_next.pins.sck_o = 1'b1;
                    state_next.shifter = {state_reg.shifter[6:0], state_reg.sync.miso[1]};
                    state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
                    state_next.state = st_high;
                end
            end
            st_high: begin
                if (state_reg.div_cnt != 4'h0) begin
                    state_next.div_cnt = state_reg.div_cnt - 4'h1;
                end else begin
                    state_next.pins.sck_o = 1'b0;
                    state_next.out_bit = state_reg.shifter[7];
                    if (state_reg.bit_cnt == bits_per_byte) begin
                        last_edge = 1'b1;
                        state_next.state = st_idle;
                        state_next.busy = 1'b0;
                    end else begin
                        state_next.div_cnt = sck_half_load;
                        state_next.state = st_low;
                    end
                end
            end
        endcase

        // Slave shifting from the sampled link clock
        if (!is_master && enabled && !ss_level) begin
            if (sck_rise) begin
                state_next.shifter = {state_reg.shifter[6:0], state_reg.sync.mosi[1]};
                state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
                state_next.busy = 1'b1;
                if (state_reg.bit_cnt == bits_per_byte - 4'h1) begin
                    last_edge = 1'b1;
                    state_next.bit_cnt = 4'h0;
                    state_next.busy = 1'b0;
                end
            end
            if (sck_fall) begin
                state_next.out_bit = state_reg.shifter[7];
            end
        end
        if (!is_master && ss_level) begin
            state_next.bit_cnt = 4'h0;
            state_next.busy = 1'b0;
        end

        // Byte complete: buffer it or flag overrun
        if (last_edge) begin
            if (state_reg.done) begin
                state_next.overrun_flag = 1'b1;
                ev_ovr_p = 1'b1;
            end else begin
                // Master holds all eight bits by the last fall; slave takes its last bit now
                state_next.rx_buf = is_master ? state_reg.shifter : {state_reg.shifter[6:0],
                    state_reg.sync.mosi[1]};
                state_next.done = 1'b1;
                state_next.done_armed = 1'b0;
                ev_done_p = 1'b1;
            end
        end

        if (sel_fault) begin
            state_next.mode_fault_flag = 1'b1;
            state_next.mode_fault_flag_armed = 1'b0;
            state_next.control[bit_port_en] = 1'b0;
            state_next.control[bit_master] = 1'b0;
            state_next.state = st_idle;
            state_next.busy = 1'b0;
            ev_mode_fault_flag_p = 1'b1;
        end

        // Pin drive
        state_next.pins.sck_oe = state_next.control[bit_port_en] && state_next.control[bit_master];
        state_next.pins.mosi_o = state_next.out_bit;
        state_next.pins.miso_o = state_next.out_bit;
        state_next.pins.mosi_oe = state_next.control[bit_port_en] && state_next.control[bit_master]
            && !state_next.csr_low[bit_sod];
        state_next.pins.miso_oe = state_next.control[bit_port_en]
            && !state_next.control[bit_master] && !state_next.csr_low[bit_sod] && !ss_level;

        // Sticky interrupt status: set wins over read clear
        if (rd_irq) begin
            state_next.irq_status = irq_reset;
        end
        if (wr_mask) begin
            state_next.irq_mask = hwdata[3:0];
        end
        if (ev_done_p) begin
            state_next.irq_status[ev_done] = 1'b1;
        end
        if (ev_ovr_p) begin
            state_next.irq_status[ev_ovr] = 1'b1;
        end
        if (ev_mode_fault_flag_p) begin
            state_next.irq_status[ev_mode_fault_flag] = 1'b1;
        end
        if (ev_write_collision_flag_p) begin
            state_next.irq_status[ev_write_collision_flag] = 1'b1;
        end
        state_next.irq = (state_next.control[bit_irq_en] && (state_next.done
            || state_next.overrun_flag || state_next.mode_fault_flag))
            || |(state_next.irq_status & state_next.irq_mask);

        // Read data taken after this edge's updates, so no event set here goes unreported
        if (take && !hwrite) begin
            state_next.rdata = read_mux(state_next, haddr[9:0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
            state_reg.control <= control_reset;
            state_reg.irq_mask <= irq_reset;
            state_reg.state <= st_idle;
            state_reg.sync.ss_n <= 2'b11;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

// file: tb/serial_port_properties.sv
`timescale 1ns/10ps
module serial_port_properties
    import serial_port_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Pins and interrupt
    input wire pins_out_type pins_o,
    input wire logic irq
);
    logic take;
    logic rd_status_reg;
    logic wr_control_reg;
    logic irq_en_reg;
    assign take = hsel && hready && htrans[1];
    // Shadow of the interrupt enable, tracked from control writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_status_reg <= 1'b0;
            wr_control_reg <= 1'b0;
            irq_en_reg <= 1'b0;
        end else begin
            rd_status_reg <= take && !hwrite && haddr[9:0] == addr_status;
            wr_control_reg <= take && hwrite && haddr[9:0] == addr_control;
            if (wr_control_reg) begin
                irq_en_reg <= hwdata[bit_irq_en];
            end
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_half_period: assert property ($rose(pins_o.sck_o) |-> pins_o.sck_o[*4] ##1 !pins_o.sck_o)
        else $error("serial clock half period wrong");
    a_clock_driven: assert property ($rose(pins_o.sck_o) |-> pins_o.sck_oe)
        else $error("serial clock toggles undriven");
    a_mosi_steady: assert property (pins_o.sck_o && $past(pins_o.sck_o) |-> $stable(pins_o.mosi_o))
        else $error("data out moved while clock high");
    a_master_no_miso: assert property (pins_o.mosi_oe |-> !pins_o.miso_oe)
        else $error("both data outputs driven");
    a_slave_no_sck: assert property (pins_o.miso_oe |-> !pins_o.sck_oe)
        else $error("slave drives serial clock");
    a_reserved_zero: assert property (rd_status_reg |-> hrdata[3] == 1'b0 && hrdata[31:8] == 24'h00_0000)
        else $error("reserved status bits set");
    a_irq_on_flag: assert property (rd_status_reg && irq_en_reg && (hrdata[7] || hrdata[5] || hrdata[4]) |-> irq)
        else $error("flag set without interrupt");
    a_reset_quiet: assert property ($rose(hresetn) |-> !irq && !pins_o.sck_o)
        else $error("outputs active after reset");
    c_transfer: cover property ($rose(pins_o.sck_o));
    c_slave: cover property ($rose(pins_o.miso_oe));
    c_irq: cover property ($rose(irq));
endmodule

bind serial_port serial_port_properties serial_port_properties_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .pins_o(pins_o), .irq(irq));

// file: tb/serial_slave_model.sv
`timescale 1ns/10ps
module serial_slave_model (
    // Link
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Bench side
    input wire logic [7:0] reply,
    output logic [7:0] got,
    output int bits
);
    logic [7:0] got_reg = 8'h00;
    int rises = 0;
    int falls = 0;
    assign got = got_reg;
    assign bits = rises;
    // Reply bit for the current position; the first bit stands before the first rise
    assign miso = reply[7 - (falls % 8)];
    // Capture on rise, next bit on fall
    always @(posedge sck) begin
        got_reg <= {got_reg[6:0], mosi};
        rises <= rises + 1;
    end
    // Only a fall that follows a rise counts, not the settling of the clock at start
    always @(negedge sck) begin
        if (rises > falls) begin
            falls <= falls + 1;
        end
    end
endmodule

// file: tb/serial_port_status_and_data_bench.sv
`timescale 1ns/10ps
module serial_port_status_and_data_bench
    import serial_port_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic sck_i = 1'b0;
    logic ss_n_i = 1'b1;
    logic mosi_i = 1'b0;
    logic miso_w;
    pins_out_type pins_o;
    logic irq;
    logic [7:0] reply = 8'h00;
    logic [7:0] got;
    int bits;
    int mismatches = 0;
    int num_checks = 0;

    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    serial_port serial_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sck_i(sck_i), .ss_n_i(ss_n_i),
        .mosi_i(mosi_i), .miso_i(miso_w), .pins_o(pins_o), .irq(irq));
    serial_slave_model serial_slave_model_inst (.sck(pins_o.sck_o), .mosi(pins_o.mosi_o),
        .miso(miso_w), .reply(reply), .got(got), .bits(bits));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        haddr <= {22'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        chk(32'(hresp), 32'h0000_0000);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rc(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        chk(r, e);
    endtask
    task automatic wait_irq(input logic v);
        repeat (400) if (irq !== v) @(posedge hclk);
        chk(32'(irq), 32'(v));
    endtask
    // External master with 62.5 ns half periods; clock idles low between frames
    task automatic send(input logic [7:0] b, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            mosi_i <= b[i];
            #62.5 r = {r[6:0], pins_o.miso_o};
            sck_i <= 1'b1;
            #62.5 sck_i <= 1'b0;
        end
    endtask

    task automatic t_reset();
        rc(addr_status, 32'h0000_0000);
        rc(addr_control, 32'h0000_0000);
        rc(addr_irq_status, 32'h0000_0000);
        rc(10'h3fc, 32'h0000_0000);
    endtask
    task automatic t_master();
        wr(addr_status, 8'h03);
        wr(addr_control, 8'hd0);
        reply = 8'ha5;
        wr(addr_data, 8'h3c);
        chk(32'(pins_o.mosi_oe), 32'h1);
        chk(32'(pins_o.sck_oe), 32'h1);
        wr(addr_data, 8'hff);
        wait_irq(1'b1);
        chk(32'(got), 32'h3c);
        chk(32'(bits), 32'h8);
        rc(addr_status, 32'h0000_00c3);
        rc(addr_data, 32'h0000_00a5);
        rc(addr_status, 32'h0000_0003);
        chk(32'(irq), 32'h0);
    endtask
    task automatic t_inhibit();
        reply = 8'h69;
        wr(addr_data, 8'h5a);
        wait_irq(1'b1);
        wr(addr_data, 8'h11);
        repeat (100) @(posedge hclk);
        chk(32'(bits), 32'h10);
        chk(32'(got), 32'h5a);
        rc(addr_status, 32'h0000_0083);
        rc(addr_data, 32'h0000_0069);
        rc(addr_status, 32'h0000_0003);
    endtask
    task automatic t_slave();
        logic [7:0] r;
        wr(addr_control, 8'hc0);
        wr(addr_status, 8'h02);
        wr(addr_data, 8'hc3);
        repeat (2) @(posedge hclk);
        chk(32'(pins_o.miso_oe), 32'h1);
        chk(32'(pins_o.sck_oe), 32'h0);
        send(8'h9a, r);
        chk(32'(r), 32'h0000_00c3);
        send(8'h47, r);
        chk(32'(r), 32'h0000_009a);
        repeat (20) @(posedge hclk);
        chk(32'(irq), 32'h1);
        rc(addr_status, 32'h0000_00a2);
        rc(addr_data, 32'h0000_009a);
        rc(addr_status, 32'h0000_0002);
        wr(addr_status, 8'h06);
        repeat (2) @(posedge hclk);
        chk(32'(pins_o.miso_oe), 32'h0);
    endtask
    task automatic t_fault();
        wr(addr_status, 8'h00);
        rc(addr_irq_status, 32'h0000_000b);
        wr(addr_control, 8'hd0);
        ss_n_i <= 1'b0;
        repeat (10) @(posedge hclk);
        ss_n_i <= 1'b1;
        wr(addr_control, 8'h80);
        rc(addr_status, 32'h0000_0010);
        rc(addr_control, 32'h0000_0080);
        chk(32'(pins_o.sck_oe), 32'h0);
        chk(32'(irq), 32'h1);
        wr(addr_control, 8'h00);
        rc(addr_status, 32'h0000_0000);
        chk(32'(irq), 32'h0);
        wr(addr_irq_mask, 8'h04);
        wait_irq(1'b1);
        rc(addr_irq_status, 32'h0000_0004);
        wait_irq(1'b0);
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #200_000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_master();
        t_inhibit();
        t_slave();
        t_fault();
        conclude();
    end
endmodule
